// ===== core/scpm_ctrl.v
// system clock selection and operating mode controller with axi4-lite registers
`timescale 1ns/1ps
`include "scpm_regs.vh"
// Function
// - The system clock comes from the high-frequency clock or the sub clock, chosen by the three-bit select field.
// - In fast mode the high-speed clock is divided by 1 to 64 as the select field says.
// - The high-frequency clock comes only from the internal fast rc oscillator.
// - The sub clock comes from the external slow crystal or the internal slow rc, chosen by the source bit.
// - Moving the system clock to the sub clock stops or keeps the high-speed oscillator per its enable bit.
// - In slow mode the high-frequency clock follows its oscillator enable bit while the cpu runs on the sub clock.
// - In fast and slow mode the cpu, sub clock and watchdog clock run regardless of both keep-alive bits.
// - A halt with both keep-alive bits low enters sleep with cpu, high clock and sub clock stopped.
// - The watchdog rc clock runs in every mode.
// - A halt with only the low-speed keep-alive set stops cpu and high clock and keeps the system clock only for 111.
// - A halt with both keep-alive bits set stops only the cpu.
// - A halt with only the high-speed keep-alive set stops cpu and sub clock, keeping the system clock for 000~110 only if the oscillator enable bit is set.
// - The source bit selects the internal slow rc when 0 and the external slow crystal when 1.
// - A select or source change completes only after four current system clock periods plus a variable part.
module scpm_ctrl (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// oscillator clock levels from pins or analog cells
	input wire internal_fast_rc,
	input wire external_slow_crystal,
	input wire internal_slow_rc,
	// wake event from outside logic
	input wire wake_req,
	// derived clocks and gates
	output reg sys_clk_q,
	output reg high_freq_clock_q,
	output reg sub_clock_q,
	output reg watchdog_rc_clock_q,
	output reg cpu_run_q,
	output reg hs_osc_en_q,
	output reg [2:0] mode_q
);
	// synchronisers for the asynchronous oscillator levels and wake
	reg [3:0] sy1_q;
	reg [3:0] sy2_q;
	reg hf_prev_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sy1_q <= 4'h0;
			sy2_q <= 4'h0;
			hf_prev_q <= 1'b0;
		end else begin
			sy1_q <= {wake_req, internal_slow_rc, external_slow_crystal, internal_fast_rc};
			sy2_q <= sy1_q;
			hf_prev_q <= sy2_q[0];
		end
	end
	wire hf_lvl = sy2_q[0];
	wire hf_rise = hf_lvl & ~hf_prev_q;
	wire wake_lvl = sy2_q[3];

	// software registers
	reg [`SCPM_SEL_W-1:0] sel_q;
	reg fss_q;
	reg hsk_q;
	reg lsk_q;
	reg hs_en_q;
	reg halt_p;
	reg wake_p;
	wire [2:0] mode_d;

	// divider of the high-frequency clock, stopped when the oscillator is off
	wire [5:0] div_lvl;
	scpm_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.src_rise(hf_rise),
		.run(hs_osc_en_q),
		.div_q(div_lvl)
	);

	// fast-mode source: ratio 1 to 64 from the select code
	reg fast_lvl;
	always @* begin
		case (sel_q)
			3'h0: fast_lvl = hf_lvl & hs_osc_en_q; // only the fast rc feeds this
			3'h1: fast_lvl = div_lvl[0];
			3'h2: fast_lvl = div_lvl[1];
			3'h3: fast_lvl = div_lvl[2];
			3'h4: fast_lvl = div_lvl[3];
			3'h5: fast_lvl = div_lvl[4];
			3'h6: fast_lvl = div_lvl[5];
			default: fast_lvl = 1'b0;
		endcase
	end

	// sub clock source: 0 slow rc, 1 crystal, switched glitch-free
	wire sub_lvl;
	wire sub_own_xtal;
	scpm_gsw u_subsw (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_a(sy2_q[2]),
		.clk_b(sy2_q[1]),
		.sel_b(fss_q),
		.clk_q(sub_lvl),
		.own_b_q(sub_own_xtal)
	);

	// system clock: divided fast clock or sub clock, switched glitch-free
	wire sys_lvl;
	wire sys_own_sub;
	scpm_gsw u_syssw (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_a(fast_lvl),
		.clk_b(sub_lvl),
		.sel_b(sel_q == `SCPM_SEL_SUB),
		.clk_q(sys_lvl),
		.own_b_q(sys_own_sub)
	);

	// settle counter: four rising edges of the current system clock after a change
	reg [2:0] settle_q;
	reg sys_prev_q;
	wire sys_rise = sys_lvl & ~sys_prev_q;
	wire sel_wr;
	always @(posedge aclk) begin
		if (!aresetn) begin
			settle_q <= 3'h0;
			sys_prev_q <= 1'b0;
		end else begin
			sys_prev_q <= sys_lvl;
			if (sel_wr)
				settle_q <= `SCPM_SWITCH_PERIODS;
			else if (settle_q != 3'h0 && sys_rise)
				settle_q <= settle_q - 3'h1;
		end
	end
	// busy also while a switch has not yet handed over ownership
	wire busy = (settle_q != 3'h0) | (sys_own_sub != (sel_q == `SCPM_SEL_SUB)) | (sub_own_xtal != fss_q);

	// halt samples the keep-alive bits at that instant; the select stays live
	assign mode_d = (!hsk_q && !lsk_q) ? `SCPM_MODE_SLEEP :
		(!hsk_q && lsk_q) ? `SCPM_MODE_SBY_SUB :
		(hsk_q && lsk_q) ? `SCPM_MODE_SBY_BOTH :
		`SCPM_MODE_SBY_FAST;
	wire run_mode = (sel_q == `SCPM_SEL_SUB);
	wire [2:0] run_code = run_mode ? `SCPM_MODE_SLOW : `SCPM_MODE_FAST;
	wire halted = (mode_q != `SCPM_MODE_FAST) && (mode_q != `SCPM_MODE_SLOW);
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= `SCPM_MODE_FAST;
		end else if (!halted) begin
			if (halt_p)
				mode_q <= mode_d;
			else
				mode_q <= run_code;
		end else if (wake_p || wake_lvl) begin
			mode_q <= run_code;
		end
	end

	// clock gating per operating mode
	reg sys_on;
	reg hf_on;
	reg sub_on;
	always @* begin
		sys_on = 1'b1;
		hf_on = hs_en_q;
		sub_on = 1'b1;
		case (mode_q)
			`SCPM_MODE_FAST: hf_on = 1'b1; // keep-alive bits ignored
			`SCPM_MODE_SLOW: hf_on = hs_en_q;
			`SCPM_MODE_SLEEP: begin
				sys_on = 1'b0;
				hf_on = 1'b0;
				sub_on = 1'b0;
			end
			`SCPM_MODE_SBY_SUB: begin
				sys_on = (sel_q == `SCPM_SEL_SUB);
				hf_on = 1'b0;
			end
			`SCPM_MODE_SBY_BOTH: hf_on = 1'b1;
			`SCPM_MODE_SBY_FAST: begin
				sys_on = (sel_q != `SCPM_SEL_SUB);
				sub_on = 1'b0;
			end
			default: begin
				sys_on = 1'b1;
				hf_on = 1'b1;
			end
		endcase
	end

	// registered clock and gate outputs; the system and sub clock gates let a level rise only on a fresh source edge
	// and never cut a high phase short, so no runt appears there; the high clock is masked directly by hs_osc_en_q
	reg sub_prev_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk_q <= 1'b0;
			high_freq_clock_q <= 1'b0;
			sub_clock_q <= 1'b0;
			sub_prev_q <= 1'b0;
			watchdog_rc_clock_q <= 1'b0;
			cpu_run_q <= 1'b0;
			hs_osc_en_q <= `SCPM_HSEN_RST;
		end else begin
			hs_osc_en_q <= hf_on;
			sys_clk_q <= sys_lvl & (sys_clk_q | (sys_on & ~sys_prev_q));
			high_freq_clock_q <= hf_lvl & hs_osc_en_q;
			sub_prev_q <= sub_lvl;
			sub_clock_q <= sub_lvl & (sub_clock_q | (sub_on & ~sub_prev_q));
			watchdog_rc_clock_q <= sy2_q[2]; // always on
			cpu_run_q <= !halted;
		end
	end

	// axi4-lite write channel: address and data in either order
	reg aw_hold_q;
	reg w_hold_q;
	reg [11:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign sel_wr = do_wr && (aw_addr_q == `SCPM_OFF_CTRL) && w_strb_q[0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SCPM_RESP_OKAY;
			sel_q <= 3'h0;
			fss_q <= 1'b0;
			hsk_q <= 1'b0;
			lsk_q <= 1'b0;
			hs_en_q <= `SCPM_HSEN_RST;
			halt_p <= 1'b0;
			wake_p <= 1'b0;
		end else begin
			halt_p <= 1'b0;
			wake_p <= 1'b0;
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `SCPM_RESP_OKAY;
				case (aw_addr_q)
					`SCPM_OFF_CTRL: if (w_strb_q[0]) begin
						sel_q <= w_data_q[`SCPM_SEL_HI:`SCPM_SEL_LO];
						fss_q <= w_data_q[`SCPM_FSS_BIT];
						hsk_q <= w_data_q[`SCPM_HSK_BIT];
						lsk_q <= w_data_q[`SCPM_LSK_BIT];
					end
					`SCPM_OFF_HSEN: if (w_strb_q[0])
						hs_en_q <= w_data_q[0];
					`SCPM_OFF_CMD: if (w_strb_q[0]) begin
						halt_p <= w_data_q[`SCPM_CMD_HALT];
						wake_p <= w_data_q[`SCPM_CMD_WAKE];
					end
					`SCPM_OFF_STAT: s_axi_bresp <= `SCPM_RESP_OKAY;
					default: s_axi_bresp <= `SCPM_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi4-lite read channel: one cycle to accept, data the next
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SCPM_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SCPM_RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				case (s_axi_araddr)
					`SCPM_OFF_CTRL: s_axi_rdata <= {24'h00_0000, sel_q, 2'h0, fss_q, hsk_q, lsk_q};
					`SCPM_OFF_HSEN: s_axi_rdata <= {31'h0000_0000, hs_en_q};
					`SCPM_OFF_STAT: s_axi_rdata <= {21'h00_0000, sel_q, 3'h0, busy, 1'b0, mode_q};
					`SCPM_OFF_CMD: s_axi_rdata <= 32'h0000_0000;
					default: s_axi_rresp <= `SCPM_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // scpm_ctrl

// ===== core/scpm_regs.vh
// register map, field positions, reset values and timing constants for the clock and mode controller
`ifndef SCPM_REGS_VH
`define SCPM_REGS_VH

// register byte offsets
`define SCPM_OFF_CTRL 12'h000
`define SCPM_OFF_HSEN 12'h004
`define SCPM_OFF_STAT 12'h008
`define SCPM_OFF_CMD 12'h00c
`define SCPM_ADDR_W 12

// control register fields
`define SCPM_SEL_HI 7
`define SCPM_SEL_LO 5
`define SCPM_FSS_BIT 2
`define SCPM_HSK_BIT 1
`define SCPM_LSK_BIT 0
`define SCPM_CTRL_MASK 32'h0000_00e7
`define SCPM_CTRL_RST 8'h00
`define SCPM_HSEN_RST 1'b1

// system clock select codes
`define SCPM_SEL_SUB 3'h7
`define SCPM_SEL_W 3

// command register: bit 0 executes a halt, bit 1 wakes
`define SCPM_CMD_HALT 0
`define SCPM_CMD_WAKE 1

// status fields
`define SCPM_ST_MODE_LO 0
`define SCPM_ST_BUSY 4
`define SCPM_ST_SEL_LO 8

// operating mode codes
`define SCPM_MODE_FAST 3'h0
`define SCPM_MODE_SLOW 3'h1
`define SCPM_MODE_SLEEP 3'h2
`define SCPM_MODE_SBY_SUB 3'h3
`define SCPM_MODE_SBY_BOTH 3'h4
`define SCPM_MODE_SBY_FAST 3'h5

// switch settle: four periods of the current system clock
`define SCPM_SWITCH_PERIODS 3'h4

// axi responses
`define SCPM_RESP_OKAY 2'h0
`define SCPM_RESP_SLVERR 2'h2

`endif

// ===== core/scpm_div.v
// ripple-free divider chain giving the high-speed clock over 2 to 64
`timescale 1ns/1ps
module scpm_div (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// source clock rising-edge strobe (sampled) and run enable
	input wire src_rise,
	input wire run,
	// divided levels, bit k is source over 2^(k+1)
	output reg [5:0] div_q
);
	// each stage toggles when all lower stages are high at a source rise
	wire [6:0] carry;
	assign carry[0] = src_rise & run;
	genvar k;
	generate
		for (k = 0; k < 6; k = k + 1) begin : g_stage
			assign carry[k+1] = carry[k] & div_q[k];
			always @(posedge aclk) begin
				if (!aresetn)
					div_q[k] <= 1'b0;
				else if (carry[k])
					div_q[k] <= ~div_q[k];
			end
		end
	endgenerate
endmodule // scpm_div

// ===== core/scpm_gsw.v
// glitch-free two-way clock switch working on sampled clock levels
`timescale 1ns/1ps
module scpm_gsw (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// candidate clock levels
	input wire clk_a,
	input wire clk_b,
	// 1 selects clk_b
	input wire sel_b,
	// switched clock and currently owning side
	output reg clk_q,
	output reg own_b_q
);
	reg own_a_q;
	// release the old side only in its low phase, claim the new one only when the old is released,
	// so no shortened phase reaches the output
	always @(posedge aclk) begin
		if (!aresetn) begin
			own_a_q <= 1'b1;
			own_b_q <= 1'b0;
			clk_q <= 1'b0;
		end else begin
			if (own_a_q && sel_b && !clk_a)
				own_a_q <= 1'b0;
			else if (!own_a_q && !own_b_q && !sel_b && !clk_a)
				own_a_q <= 1'b1;
			if (own_b_q && !sel_b && !clk_b)
				own_b_q <= 1'b0;
			else if (!own_a_q && !own_b_q && sel_b && !clk_b)
				own_b_q <= 1'b1;
			clk_q <= (own_a_q & clk_a) | (own_b_q & clk_b);
		end
	end
endmodule // scpm_gsw

// ===== verif/scpm_properties.sv
// concurrent checks on the clock and mode controller ports
`timescale 1ns/1ps
`include "scpm_regs.vh"
module scpm_props (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bus answers
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// clocks and mode
	input wire internal_slow_rc,
	input wire sys_clk_q,
	input wire high_freq_clock_q,
	input wire sub_clock_q,
	input wire watchdog_rc_clock_q,
	input wire cpu_run_q,
	input wire hs_osc_en_q,
	input wire [2:0] mode_q
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// modes held long enough for gated clocks to settle
	sequence sleep_held; (mode_q == `SCPM_MODE_SLEEP) [*8]; endsequence
	sequence sub_held; (mode_q == `SCPM_MODE_SBY_SUB) [*8]; endsequence
	sequence both_held; (mode_q == `SCPM_MODE_SBY_BOTH) [*8]; endsequence
	// a gated clock first finishes its high phase, which on the sub clock lasts up to ten cycles
	sequence sleep_long; sleep_held ##1 sleep_held; endsequence
	AST_SLEEP_GATE: assert property (sleep_long |-> !(cpu_run_q | sys_clk_q | high_freq_clock_q | sub_clock_q))
		else $error("clock left running in sleep");
	AST_SUB_ONLY: assert property (sub_held |-> !cpu_run_q && !high_freq_clock_q)
		else $error("fast clock running in sub standby");
	AST_BOTH_OSC: assert property (both_held |-> !cpu_run_q && hs_osc_en_q)
		else $error("oscillator stopped in dual standby");
	// cpu may lag a mode change by two cycles
	AST_RUN_CPU: assert property ((mode_q <= `SCPM_MODE_SLOW) [*3] |-> cpu_run_q)
		else $error("cpu stopped in a running mode");
	AST_HALT_CPU: assert property ((mode_q >= `SCPM_MODE_SLEEP) [*3] |-> !cpu_run_q)
		else $error("cpu running in a halt mode");
	AST_FAST_OSC: assert property ((mode_q == `SCPM_MODE_FAST) [*3] |-> hs_osc_en_q)
		else $error("oscillator off in fast mode");
	AST_WDT_RUN: assert property ($rose(internal_slow_rc) |-> ##[1:6] $rose(watchdog_rc_clock_q))
		else $error("watchdog clock did not follow");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready held");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_ANSWER: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // scpm_props

// ===== verif/tb_top.sv
// self-checking bench for the clock and mode controller
`timescale 1ns/1ps
`include "scpm_regs.vh"
module tb_top;
	// stimulus
	reg aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg [11:0] awaddr = 12'h000, araddr = 12'h000;
	reg [31:0] wdata = 32'h0, rdat;
	reg [3:0] wstrb = 4'hf;
	reg frc = 1'b0, src = 1'b0, xtal = 1'b0, wake_req = 1'b0;
	// design answers
	wire awready, wready, bvalid, arready, rvalid, sys_clk_q, high_freq_clock_q, sub_clock_q;
	wire watchdog_rc_clock_q, cpu_run_q, hs_osc_en_q;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] mode_q;
	integer failures = 0, n_tests = 0, cyc = 0, e_sys = 0, e_hf = 0, e_sub = 0, e_wd = 0;
	integer m_sys, m_hf, m_sub, m_wd;
	reg p_sys = 1'b0, p_hf = 1'b0, p_sub = 1'b0, p_wd = 1'b0;

	scpm_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .internal_fast_rc(frc),
		.external_slow_crystal(xtal), .internal_slow_rc(src), .wake_req(wake_req), .sys_clk_q(sys_clk_q),
		.high_freq_clock_q(high_freq_clock_q), .sub_clock_q(sub_clock_q),
		.watchdog_rc_clock_q(watchdog_rc_clock_q), .cpu_run_q(cpu_run_q), .hs_osc_en_q(hs_osc_en_q),
		.mode_q(mode_q));

	always #50 aclk = ~aclk;
	// free oscillators: fast rc 4 cycles, slow rc 16, crystal 20; counts of output rising edges
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		frc <= cyc[1];
		src <= cyc[3];
		xtal <= (cyc % 20) < 10;
		{p_sys, p_hf, p_sub, p_wd} <= {sys_clk_q, high_freq_clock_q, sub_clock_q, watchdog_rc_clock_q};
		e_sys <= e_sys + (sys_clk_q & !p_sys);
		e_hf <= e_hf + (high_freq_clock_q & !p_hf);
		e_sub <= e_sub + (sub_clock_q & !p_sub);
		e_wd <= e_wd + (watchdog_rc_clock_q & !p_wd);
	end

	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %s exp %h got %h", what, exp, got);
			end
		end
	endtask
	// edge counts may lose one edge at the window ends
	task near(input string what, input integer exp, input integer got);
		begin
			n_tests = n_tests + 1;
			if (exp == 0 ? got != 0 : (got > exp + 1 || got + 1 < exp)) begin
				failures = failures + 1;
				$display("CHECK FAILED %s exp %0d got %0d", what, exp, got);
			end
		end
	endtask
	task tmo;
		begin
			failures = failures + 1;
			$display("CHECK FAILED timeout exp 0 got 1");
			report_and_stop;
		end
	endtask
	task wr(input [11:0] a, input [31:0] d, input [1:0] er);
		integer i;
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (i = 0; i < 50; i = i + 1) begin
				@(posedge aclk);
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				if (bvalid)
					break;
			end
			if (i == 50)
				tmo;
			chk("bresp", er, bresp);
			bready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task rd(input [11:0] a, input [1:0] er);
		integer i;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (i = 0; i < 50; i = i + 1) begin
				@(posedge aclk);
				if (arready)
					arvalid <= 1'b0;
				if (rvalid)
					break;
			end
			if (i == 50)
				tmo;
			rdat = rdata;
			chk("rresp", er, rresp);
			rready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	// poll until the clock switch settles
	task idle;
		integer i;
		begin
			for (i = 0; i < 400; i = i + 1) begin
				rd(`SCPM_OFF_STAT, `SCPM_RESP_OKAY);
				if (rdat[`SCPM_ST_BUSY] === 1'b0)
					break;
			end
			if (i == 400)
				tmo;
		end
	endtask
	task meas(input integer n);
		integer a, b, c, w;
		begin
			a = e_sys;
			b = e_hf;
			c = e_sub;
			w = e_wd;
			repeat (n) @(posedge aclk);
			m_sys = e_sys - a;
			m_hf = e_hf - b;
			m_sub = e_sub - c;
			m_wd = e_wd - w;
		end
	endtask

	task t_reset;
		begin
			rd(`SCPM_OFF_CTRL, `SCPM_RESP_OKAY);
			chk("ctrl", 0, rdat);
			rd(`SCPM_OFF_HSEN, `SCPM_RESP_OKAY);
			chk("hsen", 1, rdat);
			rd(`SCPM_OFF_STAT, `SCPM_RESP_OKAY);
			chk("mode", `SCPM_MODE_FAST, rdat[2:0]);
			chk("cpu", 1, cpu_run_q);
			wr(12'h010, 32'h1, `SCPM_RESP_SLVERR);
			rd(12'h010, `SCPM_RESP_SLVERR);
			chk("bad", 0, rdat);
		end
	endtask
	task t_div;
		integer s;
		begin
			for (s = 0; s < 7; s = s + 1) begin
				wr(`SCPM_OFF_CTRL, s << 5, `SCPM_RESP_OKAY);
				rd(`SCPM_OFF_STAT, `SCPM_RESP_OKAY);
				if (s == 6)
					chk("busy", 1, rdat[`SCPM_ST_BUSY]);
				idle;
				chk("sel", s, rdat[`SCPM_ST_SEL_LO +: 3]);
				meas(1024);
				near("sys", 256 >> s, m_sys);
				near("hf", 256, m_hf);
			end
		end
	endtask
	task t_slow;
		integer f;
		begin
			for (f = 0; f < 2; f = f + 1) begin
				wr(`SCPM_OFF_CTRL, 32'he0 | (f << 2), `SCPM_RESP_OKAY);
				idle;
				chk("mode", `SCPM_MODE_SLOW, mode_q);
				meas(320);
				near("sub", f ? 16 : 20, m_sub);
				near("sys", f ? 16 : 20, m_sys);
			end
			wr(`SCPM_OFF_HSEN, 32'h0, `SCPM_RESP_OKAY);
			meas(72);
			chk("osc", 0, hs_osc_en_q);
			meas(64);
			near("hf", 0, m_hf);
			wr(`SCPM_OFF_HSEN, 32'h1, `SCPM_RESP_OKAY);
			meas(72);
			meas(64);
			near("hf", 16, m_hf);
		end
	endtask
	// every keep-alive pair against the undivided fast and the sub system clock
	task t_halt;
		integer k, s, i;
		reg [2:0] em;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				for (s = 0; s < 8; s = s + 7) begin
					wr(`SCPM_OFF_CTRL, (s << 5) | k, `SCPM_RESP_OKAY);
					idle;
					wr(`SCPM_OFF_CMD, 32'h1, `SCPM_RESP_OKAY);
					meas(8);
					meas(128);
					em = k == 0 ? `SCPM_MODE_SLEEP : k == 1 ? `SCPM_MODE_SBY_SUB : k == 3 ? `SCPM_MODE_SBY_BOTH : `SCPM_MODE_SBY_FAST;
					chk("mode", em, mode_q);
					chk("cpu", 0, cpu_run_q);
					near("hf", k[1] ? 32 : 0, m_hf);
					near("sub", k[0] ? 8 : 0, m_sub);
					near("sys", (k == 3 || (k == 1 && s == 7) || (k == 2 && s == 0)) ? (s ? 8 : 32) : 0, m_sys);
					near("wdt", 8, m_wd);
					wr(`SCPM_OFF_CTRL, s << 5, `SCPM_RESP_OKAY);
					chk("held", em, mode_q);
					if (s == 0)
						wake_req <= 1'b1;
					else
						wr(`SCPM_OFF_CMD, 32'h2, `SCPM_RESP_OKAY);
					for (i = 0; i < 50 && cpu_run_q !== 1'b1; i = i + 1)
						@(posedge aclk);
					if (i == 50)
						tmo;
					wake_req <= 1'b0;
					chk("wake", s ? `SCPM_MODE_SLOW : `SCPM_MODE_FAST, mode_q);
				end
			end
		end
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_div;
		t_slow;
		t_halt;
		report_and_stop;
	end
endmodule // tb_top

bind scpm_ctrl scpm_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .internal_slow_rc(internal_slow_rc), .sys_clk_q(sys_clk_q),
	.high_freq_clock_q(high_freq_clock_q), .sub_clock_q(sub_clock_q), .watchdog_rc_clock_q(watchdog_rc_clock_q),
	.cpu_run_q(cpu_run_q), .hs_osc_en_q(hs_osc_en_q), .mode_q(mode_q));
